// ==== sertx_consts.svh ====
// Register offsets, field positions, reset values and receive buffer depth of the serial block.
`ifndef SERTX_CONSTS_SVH
`define SERTX_CONSTS_SVH
`define SERTX_OFF_DATA 12'h000
`define SERTX_OFF_STATUS 12'h004
`define SERTX_OFF_CONTROL 12'h008
`define SERTX_OFF_FORMAT 12'h00c
`define SERTX_OFF_BAUD 12'h010
`define SERTX_ST_RX_DONE 7
`define SERTX_ST_TX_DONE 6
`define SERTX_ST_TX_EMPTY 5
`define SERTX_ST_FRAME_ERR 4
`define SERTX_ST_OVERRUN 3
`define SERTX_ST_PARITY_ERR 2
`define SERTX_CT_TX_EMPTY_IE 5
`define SERTX_CT_RX_EN 4
`define SERTX_CT_TX_EN 3
`define SERTX_CT_RX_NINTH 1
`define SERTX_CT_TX_NINTH 0
`define SERTX_FM_SYNC 6
`define SERTX_FM_PAR_EN 5
`define SERTX_FM_PAR_ODD 4
`define SERTX_FM_TWO_STOP 3
`define SERTX_FM_SIZE_HI 2
`define SERTX_FM_SIZE_LO 0
`define SERTX_CONTROL_RST 8'h00
`define SERTX_FORMAT_RST 8'h06
`define SERTX_BAUD_RST 16'h0000
`define SERTX_RX_DEPTH 2
`endif

// ==== sertx_pkg.sv ====
// Types shared by the serial block files.
package sertx_pkg;
  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } sertx_rx_entry_t;
  typedef struct packed {
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic [2:0] size;
  } sertx_fmt_t;
endpackage : sertx_pkg

// ==== sertx_rx_fifo.sv ====
// Two-entry receive buffer carrying data, ninth bit and error flags.
`timescale 1ns/1ps
`include "sertx_consts.svh"
module sertx_rx_fifo #(
  parameter int DEPTH = `SERTX_RX_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire sertx_pkg::sertx_rx_entry_t push_entry,
  input wire logic pop,
  output sertx_pkg::sertx_rx_entry_t head,
  output logic not_empty,
  output logic full
);
  sertx_pkg::sertx_rx_entry_t mem_r [DEPTH];
  logic [$clog2(DEPTH):0] count_r;
  logic do_pop;
  logic do_push;
  integer i;
  assign do_pop = pop && (count_r != '0);
  assign do_push = push && ((count_r != DEPTH[$clog2(DEPTH):0]) || do_pop);
  assign head = mem_r[0];
  assign not_empty = (count_r != '0);
  assign full = (count_r == DEPTH[$clog2(DEPTH):0]);
  // A pop shifts the queue so the slot frees in the same cycle.
  always_ff @(posedge clock) begin
    if (rst || flush) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
    end
  end
  // Entries start cleared so an empty buffer never shows unknown flags.
  always_ff @(posedge clock) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      if (do_pop) begin
        for (i = 0; i < DEPTH - 1; i++) begin
          mem_r[i] <= mem_r[i + 1];
        end
      end
      if (do_push) begin
        mem_r[int'(count_r) - (do_pop ? 1 : 0)] <= push_entry;
      end
    end
  end
endmodule : sertx_rx_fifo

// ==== sertx_core.sv ====
// Serial transceiver with APB registers, transmit flags and receive buffer.
`timescale 1ns/1ps
`include "sertx_consts.svh"
// **************************************************************
// Overview of operation
// **************************************************************
// **************************************************************
module sertx_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_irq_en,
  input wire logic tx_done_irq_ack,
  output logic tx_buf_empty_irq,
  output logic tx_done_irq,
  output logic rx_done_irq,
  input wire logic rx_pin,
  input wire logic ext_transfer_clock_pin,
  output logic tx_pin,
  output logic tx_pin_oe,
  output logic rx_pin_owned
);
  // **************************************************************
  // Helpers
  // **************************************************************
  function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [2:0] sz);
    logic [8:0] m;
    m = 9'h1ff;
    case (sz)
      3'h0: m = 9'h01f;
      3'h1: m = 9'h03f;
      3'h2: m = 9'h07f;
      3'h3: m = 9'h0ff;
      default: m = 9'h1ff;
    endcase
    return d & m;
  endfunction : mask_data
  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    logic [3:0] n;
    n = 4'h9;
    if (sz < 3'h4) begin
      n = 4'h5 + {1'b0, sz};
    end
    return n;
  endfunction : data_bits
  function automatic logic parity_of(input logic [8:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction : parity_of
  // **************************************************************
  // Registers
  // **************************************************************
  logic [7:0] control_r;
  sertx_pkg::sertx_fmt_t fmt_r;
  logic sync_mode_r;
  logic [15:0] baud_r;
  logic [8:0] tx_buf_r;
  logic tx_buf_full_r;
  logic tx_done_flag_r;
  logic access;
  logic wr_data;
  logic rd_data;
  logic wr_status;
  logic tx_load;
  logic tx_frame_end;
  logic tx_busy_r;
  sertx_pkg::sertx_rx_entry_t rx_head;
  logic rx_not_empty;
  logic rx_full;
  logic rx_push;
  sertx_pkg::sertx_rx_entry_t rx_push_entry;
  assign access = psel && penable;
  assign wr_data = access && pwrite && (paddr == `SERTX_OFF_DATA);
  assign rd_data = access && !pwrite && (paddr == `SERTX_OFF_DATA);
  assign wr_status = access && pwrite && (paddr == `SERTX_OFF_STATUS);
  always_ff @(posedge clock) begin
    if (rst) begin
      control_r <= `SERTX_CONTROL_RST;
      fmt_r <= sertx_pkg::sertx_fmt_t'(6'(`SERTX_FORMAT_RST));
      sync_mode_r <= 1'b0;
      baud_r <= `SERTX_BAUD_RST;
    end else if (access && pwrite) begin
      if (paddr == `SERTX_OFF_CONTROL) begin
        control_r <= pwdata[7:0];
      end
      if (paddr == `SERTX_OFF_FORMAT) begin
        fmt_r <= {pwdata[`SERTX_FM_PAR_EN], pwdata[`SERTX_FM_PAR_ODD],
                  pwdata[`SERTX_FM_TWO_STOP], pwdata[`SERTX_FM_SIZE_HI:`SERTX_FM_SIZE_LO]};
        sync_mode_r <= pwdata[`SERTX_FM_SYNC];
      end
      if (paddr == `SERTX_OFF_BAUD) begin
        baud_r <= pwdata[15:0];
      end
    end
  end
  // Status bits other than transmit-done ignore writes; software writes them as zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `SERTX_OFF_BAUD || paddr[1:0] != 2'h0);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SERTX_OFF_DATA: prdata <= {23'h0, mask_data(rx_head.data, fmt_r.size) & {1'b0, 8'hff}};
          `SERTX_OFF_STATUS: prdata <= {24'h0, rx_not_empty, tx_done_flag_r, !tx_buf_full_r,
                                        rx_head.frame_err, rx_head.overrun,
                                        rx_head.parity_err, 2'h0};
          // Ninth received bit shown beside control bits.
          `SERTX_OFF_CONTROL: prdata <= {24'h0, control_r[7:2], rx_head.data[8], control_r[0]};
          `SERTX_OFF_FORMAT: prdata <= {25'h0, sync_mode_r, fmt_r};
          `SERTX_OFF_BAUD: prdata <= {16'h0, baud_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // **************************************************************
  // Transmitter
  // **************************************************************
  logic tx_en;
  logic [15:0] tx_div_r;
  logic tx_tick;
  logic [10:0] tx_shift_r;
  logic [3:0] tx_left_r;
  logic [3:0] nbits;
  logic tx_active_r;
  assign tx_en = control_r[`SERTX_CT_TX_EN];
  assign nbits = data_bits(fmt_r.size);
  // The transmit divider runs free; a bit period is baud_r + 1 cycles.
  always_ff @(posedge clock) begin
    if (rst || tx_div_r == baud_r) begin
      tx_div_r <= 16'h0000;
    end else begin
      tx_div_r <= tx_div_r + 16'h0001;
    end
  end
  assign tx_tick = (tx_div_r == baud_r);
  assign tx_load = tx_buf_full_r && !tx_busy_r && (tx_active_r || tx_en) && tx_tick;
  assign tx_frame_end = tx_busy_r && tx_tick && (tx_left_r == 4'h1);
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_buf_full_r <= 1'b0;
      tx_buf_r <= 9'h000;
    end else if (wr_data) begin
      tx_buf_full_r <= 1'b1;
      tx_buf_r <= {control_r[`SERTX_CT_TX_NINTH], pwdata[7:0]};
    end else if (tx_load) begin
      tx_buf_full_r <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_busy_r <= 1'b0;
      tx_shift_r <= 11'h7ff;
      tx_left_r <= 4'h0;
    end else if (tx_load) begin
      tx_busy_r <= 1'b1;
      tx_shift_r <= 11'h7ff;
      tx_shift_r[0] <= 1'b0;
      tx_shift_r[4'(nbits) +: 1] <= 1'b0;
      for (int b = 0; b < 9; b++) begin
        if (b < int'(nbits)) begin
          tx_shift_r[b + 1] <= tx_buf_r[b];
        end
      end
      if (fmt_r.par_en) begin
        tx_shift_r[4'(nbits + 4'h1)] <= parity_of(mask_data(tx_buf_r, fmt_r.size), fmt_r.par_odd);
      end else begin
        tx_shift_r[4'(nbits + 4'h1)] <= 1'b1;
      end
      tx_left_r <= 4'h2 + nbits + (fmt_r.par_en ? 4'h1 : 4'h0) + (fmt_r.two_stop ? 4'h1 : 4'h0);
    end else if (tx_busy_r && tx_tick) begin
      tx_shift_r <= {1'b1, tx_shift_r[10:1]};
      tx_left_r <= tx_left_r - 4'h1;
      if (tx_left_r == 4'h1) begin
        tx_busy_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_active_r <= 1'b0;
    end else begin
      tx_active_r <= tx_en || tx_busy_r || tx_buf_full_r;
    end
  end
  // Done set on frame end with empty buffer.
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_done_flag_r <= 1'b0;
    end else if (tx_frame_end && !tx_buf_full_r) begin
      tx_done_flag_r <= 1'b1;
    end else if (tx_done_irq_ack || (wr_status && pwdata[`SERTX_ST_TX_DONE])) begin
      tx_done_flag_r <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_pin <= 1'b1;
      tx_pin_oe <= 1'b0;
      tx_buf_empty_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      rx_done_irq <= 1'b0;
    end else begin
      tx_pin <= tx_busy_r ? tx_shift_r[0] : 1'b1;
      tx_pin_oe <= tx_active_r || tx_en;
      tx_buf_empty_irq <= global_irq_en && control_r[`SERTX_CT_TX_EMPTY_IE] && !tx_buf_full_r;
      tx_done_irq <= global_irq_en && control_r[7] && tx_done_flag_r && !tx_done_irq_ack;
      rx_done_irq <= global_irq_en && control_r[6] && rx_not_empty;
    end
  end
  // **************************************************************
  // Receiver
  // **************************************************************
  typedef enum logic [1:0] {sertx_idle, sertx_start, sertx_bits} sertx_rx_state_t;
  sertx_rx_state_t rx_state_r;
  logic rx_en;
  logic rx_s1_r;
  logic rx_s2_r;
  logic xck_s1_r;
  logic xck_s2_r;
  logic xck_d_r;
  logic [15:0] rx_div_r;
  logic rx_sample;
  logic [10:0] rx_shift_r;
  logic [3:0] rx_cnt_r;
  logic rx_overrun_r;
  assign rx_en = control_r[`SERTX_CT_RX_EN];
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      xck_s1_r <= 1'b0;
      xck_s2_r <= 1'b0;
      xck_d_r <= 1'b0;
      rx_pin_owned <= 1'b0;
    end else begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      xck_s1_r <= ext_transfer_clock_pin;
      xck_s2_r <= xck_s1_r;
      xck_d_r <= xck_s2_r;
      rx_pin_owned <= rx_en;
    end
  end
  // Sync mode samples on transfer clock edge.
  assign rx_sample = sync_mode_r ? (xck_s2_r && !xck_d_r) : (rx_div_r == baud_r);
  always_ff @(posedge clock) begin
    if (rst || rx_state_r == sertx_idle || rx_div_r == baud_r) begin
      rx_div_r <= (rx_state_r == sertx_idle) ? {1'b0, baud_r[15:1]} : 16'h0000;
    end else begin
      rx_div_r <= rx_div_r + 16'h0001;
    end
  end
  always_ff @(posedge clock) begin
    if (rst || !rx_en) begin
      rx_state_r <= sertx_idle;
      rx_cnt_r <= 4'h0;
      rx_shift_r <= 11'h000;
    end else begin
      case (rx_state_r)
        sertx_idle: begin
          if (!rx_s2_r) begin
            rx_state_r <= sync_mode_r ? sertx_bits : sertx_start;
            rx_cnt_r <= 4'h0;
          end
        end
        sertx_start: begin
          if (rx_sample) begin
            rx_state_r <= rx_s2_r ? sertx_idle : sertx_bits;
          end
        end
        sertx_bits: begin
          if (rx_sample) begin
            rx_shift_r <= {rx_s2_r, rx_shift_r[10:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            // Stop after the first stop bit.
            if (rx_cnt_r == nbits + (fmt_r.par_en ? 4'h1 : 4'h0)) begin
              rx_state_r <= sertx_idle;
            end
          end
        end
        default: rx_state_r <= sertx_idle;
      endcase
    end
  end
  // First stop bit pushes the frame.
  assign rx_push = rx_en && rx_state_r == sertx_bits && rx_sample &&
                   rx_cnt_r == nbits + (fmt_r.par_en ? 4'h1 : 4'h0) && (!rx_full || rd_data);
  always_comb begin
    logic [10:0] aligned;
    aligned = {rx_s2_r, rx_shift_r[10:1]} >> (4'ha - nbits - (fmt_r.par_en ? 4'h1 : 4'h0));
    rx_push_entry.data = mask_data(aligned[8:0], fmt_r.size);
    rx_push_entry.frame_err = !rx_s2_r;
    rx_push_entry.overrun = rx_overrun_r;
    rx_push_entry.parity_err = fmt_r.par_en &&
      (parity_of(rx_push_entry.data, fmt_r.par_odd) != aligned[4'(nbits)]);
  end
  // A frame finishing into a full buffer is lost and the next entry reports it.
  always_ff @(posedge clock) begin
    if (rst || !rx_en || rx_push) begin
      rx_overrun_r <= 1'b0;
    end else if (rx_state_r == sertx_bits && rx_sample && rx_full && !rd_data &&
                 rx_cnt_r == nbits + (fmt_r.par_en ? 4'h1 : 4'h0)) begin
      rx_overrun_r <= 1'b1;
    end
  end
  // Flags and ninth bit stored with data.
  sertx_rx_fifo #(
    .DEPTH(`SERTX_RX_DEPTH)
  ) u_rx_fifo (
    .clock(clock),
    .rst(rst),
    .flush(!rx_en),
    .push(rx_push),
    .push_entry(rx_push_entry),
    .pop(rd_data),
    .head(rx_head),
    .not_empty(rx_not_empty),
    .full(rx_full)
  );
endmodule : sertx_core

// ==== sertx_core_properties.sv ====
// Port-level checker for the serial block, bound to its top module.
`timescale 1ns/1ps
`include "sertx_consts.svh"
module sertx_core_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_en,
  input wire logic tx_done_irq_ack,
  input wire logic tx_buf_empty_irq,
  input wire logic tx_done_irq,
  input wire logic rx_done_irq,
  input wire logic tx_pin,
  input wire logic tx_pin_oe,
  input wire logic rx_pin_owned
);
  // ********
  // Checks
  // ********
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite && !pslverr && paddr == `SERTX_OFF_CONTROL;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_empty_irq_gate: assert property (!global_irq_en |=> !tx_buf_empty_irq)
    else $error("empty irq while globally masked");
  a_done_irq_gate: assert property ($rose(tx_done_irq) |-> $past(global_irq_en))
    else $error("done irq while globally masked");
  a_ack_clears_done: assert property (tx_done_irq_ack && tx_done_irq |-> ##2 !tx_done_irq)
    else $error("done irq survives acknowledge");
  a_released_line_idle: assert property (!tx_pin_oe |-> tx_pin)
    else $error("pin released mid frame");
  a_rx_takeover: assert property (ctl_wr && pwdata[4] |-> ##[1:2] rx_pin_owned)
    else $error("receive pin not taken");
  a_rx_flush: assert property (ctl_wr && !pwdata[4] |-> ##[1:3] !rx_done_irq && !rx_pin_owned)
    else $error("receive buffer not flushed");
  c_tx_done: cover property ($rose(tx_done_irq));
  c_rx_done: cover property ($rose(rx_done_irq));
  c_refused: cover property (pslverr);
endmodule : sertx_core_checker
bind sertx_core sertx_core_checker chk (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .global_irq_en(global_irq_en), .tx_done_irq_ack(tx_done_irq_ack),
  .tx_buf_empty_irq(tx_buf_empty_irq), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
  .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .rx_pin_owned(rx_pin_owned));

// ==== sertx_peer.sv ====
// Remote serial peer: sends frames to the receiver and captures transmitted frames.
`timescale 1ns/1ps
module sertx_peer #(
  parameter int BIT = 4
) (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  // ********
  // Peer
  // ********
  initial line_out = 1'b1;
  task automatic send(input logic [11:0] bits, input int n);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (BIT) @(posedge clock);
    end
  endtask : send
  task automatic grab(input int n, output logic [11:0] bits);
    bits = 12'h000;
    while (line_in !== 1'b0) @(posedge clock);
    repeat (BIT / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clock);
      bits[i] = line_in;
    end
  endtask : grab
endmodule : sertx_peer

// ==== serial_tx_rx_buffer_flags_tb.sv ====
// Self-checking bench for the serial block against a remote peer model.
`timescale 1ns/1ps
`include "sertx_consts.svh"
module serial_tx_rx_buffer_flags_tb;
  // ********
  // Bench
  // ********
  localparam int BIT = 4;
  localparam int LIMIT = 20000;
  localparam logic [11:0] DAT = `SERTX_OFF_DATA;
  localparam logic [11:0] STA = `SERTX_OFF_STATUS;
  localparam logic [11:0] CTL = `SERTX_OFF_CONTROL;
  localparam logic [11:0] FMT = `SERTX_OFF_FORMAT;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic global_irq_en = 1'b0;
  logic tx_done_irq_ack = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, tx_buf_empty_irq, tx_done_irq, rx_done_irq;
  logic rx_pin, tx_pin, tx_pin_oe, rx_pin_owned, line_up;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  // A released line idles high, as its pull-up would hold it.
  assign line_up = tx_pin_oe ? tx_pin : 1'b1;
  sertx_core uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_en(global_irq_en), .tx_done_irq_ack(tx_done_irq_ack),
    .tx_buf_empty_irq(tx_buf_empty_irq), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
    .rx_pin(rx_pin), .ext_transfer_clock_pin(1'b0), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe),
    .rx_pin_owned(rx_pin_owned));
  sertx_peer #(.BIT(BIT)) peer (.clock(clock), .line_in(line_up), .line_out(rx_pin));
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  task automatic chkw(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chkw
  task automatic chkb(input string what, input logic exp, input logic got);
    chkw(what, {31'h0, exp}, {31'h0, got});
  endtask : chkb
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask : ticks
  task automatic t_reset();
    rd(STA);
    chkw("status", 32'h20, q);
    rd(FMT);
    chkw("format", 32'h06, q);
    rd(12'h014);
    chkb("unmapped err", 1'b1, e);
    chkw("unmapped data", 32'h0, q);
    $display("test reset ended");
  endtask : t_reset
  task automatic t_tx();
    logic [11:0] b0, b1;
    wr(12'h010, 32'h3);
    wr(FMT, 32'h23);
    wr(CTL, 32'ha8);
    chkb("empty irq masked", 1'b0, tx_buf_empty_irq);
    global_irq_en <= 1'b1;
    ticks(3);
    chkb("empty irq", 1'b1, tx_buf_empty_irq);
    fork
      begin
        peer.grab(10, b0);
        peer.grab(10, b1);
      end
      begin
        wr(DAT, 32'ha5);
        // The second character waits a bit tick so it cannot overwrite the first.
        ticks(BIT + 2);
        wr(DAT, 32'h07);
        rd(STA);
        chkb("empty after write", 1'b0, q[5]);
        wr(CTL, 32'h88);
        ticks(3);
        chkb("empty irq off", 1'b0, tx_buf_empty_irq);
      end
    join
    chkw("frame a5", 32'h2a5, {20'h0, b0});
    chkw("frame 07", 32'h307, {20'h0, b1});
    while (tx_done_irq !== 1'b1) @(posedge clock);
    rd(STA);
    chkb("done flag", 1'b1, q[6]);
    tx_done_irq_ack <= 1'b1;
    ticks(1);
    tx_done_irq_ack <= 1'b0;
    ticks(3);
    chkb("done irq acked", 1'b0, tx_done_irq);
    rd(STA);
    chkb("done flag acked", 1'b0, q[6]);
    $display("test tx ended");
  endtask : t_tx
  task automatic t_txoff();
    logic [11:0] b0, b1;
    wr(FMT, 32'h33);
    wr(CTL, 32'h08);
    fork
      begin
        peer.grab(10, b0);
        chkb("oe held", 1'b1, tx_pin_oe);
        peer.grab(10, b1);
      end
      begin
        wr(DAT, 32'h55);
        ticks(BIT + 2);
        wr(DAT, 32'haa);
        wr(CTL, 32'h00);
      end
    join
    chkw("odd 55", 32'h355, {20'h0, b0});
    chkw("odd aa", 32'h3aa, {20'h0, b1});
    ticks(2 * BIT);
    chkb("oe released", 1'b0, tx_pin_oe);
    rd(STA);
    chkb("done no irq", 1'b1, q[6]);
    wr(STA, 32'h40);
    rd(STA);
    chkb("done w1c", 1'b0, q[6]);
    $display("test txoff ended");
  endtask : t_txoff
  task automatic t_rx();
    wr(FMT, 32'h08);
    wr(CTL, 32'h50);
    ticks(1);
    chkb("pin owned", 1'b1, rx_pin_owned);
    peer.send(12'h035, 6);
    peer.send(12'h02a, 6);
    ticks(6);
    rd(STA);
    chkb("rx done", 1'b1, q[7]);
    chkb("rx irq", 1'b1, rx_done_irq);
    rd(DAT);
    chkw("rx short 0", 32'h15, q);
    rd(STA);
    chkb("one left", 1'b1, q[7]);
    rd(DAT);
    chkw("rx short 1", 32'h0a, q);
    rd(STA);
    chkb("rx empty", 1'b0, q[7]);
    wr(FMT, 32'h27);
    peer.send(12'h5a5, 11);
    peer.send(12'h4c3, 11);
    ticks(6);
    rd(STA);
    chkb("perr first", 1'b1, q[2]);
    rd(CTL);
    chkb("ninth first", 1'b1, q[1]);
    rd(DAT);
    chkw("nine first", 32'ha5, {24'h0, q[7:0]});
    rd(STA);
    chkb("perr second", 1'b0, q[2]);
    rd(CTL);
    chkb("ninth second", 1'b0, q[1]);
    rd(DAT);
    chkw("nine second", 32'hc3, {24'h0, q[7:0]});
    peer.send(12'h4c3, 11);
    ticks(6);
    wr(CTL, 32'h00);
    rd(STA);
    chkb("flushed", 1'b0, q[7]);
    chkb("pin freed", 1'b0, rx_pin_owned);
    $display("test rx ended");
  endtask : t_rx
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_tx();
    t_txoff();
    t_rx();
    summarize();
  end
endmodule : serial_tx_rx_buffer_flags_tb
